/* File: src/adc_wc_pkg.sv */
// Package: register offsets, field layouts, reset values and select codes for the converter control block
package adc_wc_pkg;
   localparam logic [7:0] OFS_INPUT_SELECT   = 8'hBB;
   localparam logic [7:0] OFS_BELOW_LOW      = 8'hC5;
   localparam logic [7:0] OFS_BELOW_HIGH     = 8'hC6;
   localparam logic [7:0] OFS_ABOVE_LOW      = 8'hC3;
   localparam logic [7:0] OFS_ABOVE_HIGH     = 8'hC4;
   localparam logic [7:0] OFS_REF_CONTROL    = 8'hD1;
   localparam logic [7:0] OFS_WINDOW_STATUS  = 8'hE8;

   localparam logic [5:0] RST_INPUT_SELECT   = 6'h3F;
   localparam logic [7:0] RST_BYTE           = 8'h00;
   localparam logic [3:0] RST_REF_CONTROL    = 4'h0;
   localparam logic [3:0] REF_WRITE_MASK     = 4'hF;

   localparam int         TEMP_SENSOR_ENABLE_BIT          = 2;
   localparam int         FLAG_BIT           = 0;
   localparam int         HIGH_BITS          = 4;
   localparam int         WORD_BITS          = 12;

   localparam logic [5:0] CODE_LAST_PIN      = 6'h1F;
   localparam logic [5:0] CODE_FIRST_MID     = 6'h12;
   localparam logic [5:0] CODE_FIRST_UPPER   = 6'h19;
   localparam logic [5:0] CODE_TEMP_SENSOR   = 6'h30;
   localparam logic [5:0] CODE_SUPPLY        = 6'h31;
   localparam logic [5:0] CODE_FIRST_GROUND  = 6'h32;

   localparam logic [1:0] PKG_SMALL          = 2'h0;
   localparam logic [1:0] PKG_MID            = 2'h1;
   localparam logic [1:0] PKG_LARGE          = 2'h2;

   typedef enum logic [2:0] {
      SRC_GROUND  = 3'b000,
      SRC_PIN     = 3'b001,
      SRC_TEMP    = 3'b010,
      SRC_SUPPLY  = 3'b011,
      SRC_NONE    = 3'b100
   } source_t;
endpackage : adc_wc_pkg

/* File: src/input_select_decode.sv */
// Decoder from the positive input code to the analog source routed to the converter
module input_select_decode (
   input  wire logic [5:0]  i_positive_input_code,
   input  wire logic [1:0]  i_package_variant,
   output adc_wc_pkg::source_t o_source,
   output logic      [31:0] o_pin_select_onehot
);
   logic pin_bonded;

   always_comb begin
      pin_bonded = 1'b1;
      if (i_positive_input_code >= adc_wc_pkg::CODE_FIRST_UPPER) begin
         pin_bonded = (i_package_variant == adc_wc_pkg::PKG_LARGE);
      end else if (i_positive_input_code >= adc_wc_pkg::CODE_FIRST_MID) begin
         pin_bonded = (i_package_variant != adc_wc_pkg::PKG_SMALL);
      end
   end

   always_comb begin
      o_pin_select_onehot = 32'h0000_0000;
      if (i_positive_input_code <= adc_wc_pkg::CODE_LAST_PIN) begin
         if (pin_bonded) begin
            o_source = adc_wc_pkg::SRC_PIN;
            o_pin_select_onehot[i_positive_input_code[4:0]] = 1'b1;
         end else begin
            o_source = adc_wc_pkg::SRC_NONE;
         end
      end else if (i_positive_input_code < adc_wc_pkg::CODE_TEMP_SENSOR) begin
         o_source = adc_wc_pkg::SRC_NONE;
      end else if (i_positive_input_code == adc_wc_pkg::CODE_TEMP_SENSOR) begin
         o_source = adc_wc_pkg::SRC_TEMP;
      end else if (i_positive_input_code == adc_wc_pkg::CODE_SUPPLY) begin
         o_source = adc_wc_pkg::SRC_SUPPLY;
      end else begin
         o_source = adc_wc_pkg::SRC_GROUND;
      end
   end
endmodule // input_select_decode

/* File: src/adc_window_compare.sv */
// Window comparator, input multiplexer select and sensor enable with byte-wide register access
// Functional notes
// - Below-threshold low byte register, read-write, cleared at reset.
// - Below-threshold high byte register, cleared at reset, forms upper threshold bits.
// - Inside window: flag when word above lower bound and below upper bound.
// - Outside window: flag when word below above-threshold or above below-threshold.
// - Conversion words and thresholds compare as unsigned 12-bit integers.
// - Codes 0-31 select port pins in order; 32-47 are reserved.
// - Upper two bits of input select read zero and ignore writes.
// - Temperature sensor code routes the sensor to the positive input.
// - Pins, sensor, supply, ground offered; codes from first ground code select ground.
// - Every input is single-ended against ground; no differential pairs.
// - Higher pin codes connect only on package variants bonding those pins.
// - Sensor enable is reference control bit 2, read-write, cleared at reset.
module adc_window_compare (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [7:0]  i_reg_wdata,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [11:0] i_conversion_word,
   input  wire logic        i_conversion_done,
   input  wire logic [1:0]  i_package_variant,
   output logic      [7:0]  o_reg_rdata,
   output logic             o_window_match_flag,
   output logic      [5:0]  o_positive_input_code,
   output logic      [2:0]  o_input_source,
   output logic      [31:0] o_pin_select_onehot,
   output logic             o_negative_input_ground,
   output logic             o_temp_sensor_enable,
   output logic      [3:0]  o_reference_control
);
   logic [5:0]  input_select_r;
   logic [7:0]  below_low_r;
   logic [7:0]  below_high_r;
   logic [7:0]  above_low_r;
   logic [7:0]  above_high_r;
   logic [3:0]  ref_control_r;
   logic        flag_r;
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;
   logic        flag_nxt;
   logic        inside_hit;
   logic        outside_hit;
   logic        wr_bl;
   logic        wr_bh;
   logic        wr_al;
   logic        wr_ah;
   logic [11:0] below_word;
   logic [11:0] above_word;
   logic        inside_mode;
   logic        window_hit;
   logic        flag_clear;
   adc_wc_pkg::source_t source;

   wire sel_input = (i_reg_addr == adc_wc_pkg::OFS_INPUT_SELECT);
   wire sel_bl    = (i_reg_addr == adc_wc_pkg::OFS_BELOW_LOW);
   wire sel_bh    = (i_reg_addr == adc_wc_pkg::OFS_BELOW_HIGH);
   wire sel_al    = (i_reg_addr == adc_wc_pkg::OFS_ABOVE_LOW);
   wire sel_ah    = (i_reg_addr == adc_wc_pkg::OFS_ABOVE_HIGH);
   wire sel_ref   = (i_reg_addr == adc_wc_pkg::OFS_REF_CONTROL);
   wire sel_stat  = (i_reg_addr == adc_wc_pkg::OFS_WINDOW_STATUS);

   // One write strobe per threshold byte keeps each update block to its own concern
   assign wr_bl = i_reg_wr && sel_bl;
   assign wr_bh = i_reg_wr && sel_bh;
   assign wr_al = i_reg_wr && sel_al;
   assign wr_ah = i_reg_wr && sel_ah;

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         input_select_r <= adc_wc_pkg::RST_INPUT_SELECT;
      end else if (i_reg_wr && sel_input) begin
         input_select_r <= i_reg_wdata[5:0];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         below_low_r <= adc_wc_pkg::RST_BYTE;
      end else if (wr_bl) begin
         below_low_r <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         below_high_r <= adc_wc_pkg::RST_BYTE;
      end else if (wr_bh) begin
         below_high_r <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         above_low_r <= adc_wc_pkg::RST_BYTE;
      end else if (wr_al) begin
         above_low_r <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         above_high_r <= adc_wc_pkg::RST_BYTE;
      end else if (wr_ah) begin
         above_high_r <= i_reg_wdata;
      end
   end

   // Only the writable low nibble is held; the upper bits read as zero
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ref_control_r <= adc_wc_pkg::RST_REF_CONTROL;
      end else if (i_reg_wr && sel_ref) begin
         ref_control_r <= i_reg_wdata[3:0] & adc_wc_pkg::REF_WRITE_MASK;
      end
   end

   // Right-justified 12-bit words: only the low nibble of each high byte counts
   assign below_word  = {below_high_r[adc_wc_pkg::HIGH_BITS-1:0], below_low_r};
   assign above_word  = {above_high_r[adc_wc_pkg::HIGH_BITS-1:0], above_low_r};
   assign inside_mode = (below_word > above_word);

   assign inside_hit  = (i_conversion_word > above_word) && (i_conversion_word < below_word);
   assign outside_hit = (i_conversion_word < above_word) || (i_conversion_word > below_word);

   always_comb begin
      if (inside_mode) begin
         window_hit = inside_hit;
      end else begin
         window_hit = outside_hit;
      end
   end

   // Writing zero to the flag bit clears it; a new hit in the same cycle wins
   assign flag_clear = i_reg_wr && sel_stat && !i_reg_wdata[adc_wc_pkg::FLAG_BIT];

   always_comb begin
      flag_nxt = flag_r;
      if (flag_clear) begin
         flag_nxt = 1'b0;
      end
      // The set comes last so a hit in the clear cycle is never lost
      if (i_conversion_done && window_hit) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   // Unmapped addresses read zero
   always_comb begin
      rdata_nxt = adc_wc_pkg::RST_BYTE;
      case (1'b1)
         sel_input: begin
            rdata_nxt = {2'b00, input_select_r};
         end
         sel_bl: begin
            rdata_nxt = below_low_r;
         end
         sel_bh: begin
            rdata_nxt = below_high_r;
         end
         sel_al: begin
            rdata_nxt = above_low_r;
         end
         sel_ah: begin
            rdata_nxt = above_high_r;
         end
         sel_ref: begin
            rdata_nxt = {4'h0, ref_control_r};
         end
         sel_stat: begin
            rdata_nxt = {7'h00, flag_r};
         end
         default: begin
            rdata_nxt = adc_wc_pkg::RST_BYTE;
         end
      endcase
   end

   // Read data holds until the next read strobe
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= adc_wc_pkg::RST_BYTE;
      end else if (i_reg_rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   input_select_decode u_decode (
      .i_positive_input_code (input_select_r),
      .i_package_variant     (i_package_variant),
      .o_source              (source),
      .o_pin_select_onehot   (o_pin_select_onehot)
   );

   // Sensor channel is routed regardless of enable; software must enable it first
   assign o_temp_sensor_enable    = ref_control_r[adc_wc_pkg::TEMP_SENSOR_ENABLE_BIT];
   assign o_negative_input_ground = 1'b1;
   assign o_input_source          = source;
   assign o_positive_input_code   = input_select_r;
   assign o_reference_control     = ref_control_r;
   assign o_window_match_flag     = flag_r;
   assign o_reg_rdata             = rdata_r;
endmodule // adc_window_compare

/* File: testbench/analog_front_model.sv */
// Model of the analog sources behind the converter input mux
module analog_front_model (
   input  wire logic        i_core_clk,
   input  wire logic [2:0]  i_source,
   input  wire logic        i_temp_sensor_enable,
   input  wire logic [11:0] i_pin_level,
   input  wire logic        i_go,
   output logic      [11:0] o_conversion_word = 12'h000,
   output logic             o_conversion_done = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   // Dead sources toggle the word so stale data never passes for a real sample
   always @(posedge i_core_clk) begin
      o_conversion_done <= i_go;
      case (i_source)
         3'h0: o_conversion_word <= 12'h000;
         3'h1: o_conversion_word <= i_pin_level;
         3'h2: o_conversion_word <= i_temp_sensor_enable ? 12'h3A0 : ~o_conversion_word;
         3'h3: o_conversion_word <= 12'hFFF;
         default: o_conversion_word <= ~o_conversion_word;
      endcase
   end
endmodule // analog_front_model

/* File: testbench/adc_wc_monitor.sv */
// Checker for window flag and input routing
module adc_wc_monitor (
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic [7:0]  i_reg_addr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic        i_reg_wr,
   input wire logic [11:0] i_conversion_word,
   input wire logic        i_conversion_done,
   input wire logic        o_window_match_flag,
   input wire logic [5:0]  o_positive_input_code,
   input wire logic [2:0]  o_input_source,
   input wire logic        o_negative_input_ground
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Threshold shadow: offsets 0xC3..0xC6 land on entries 0..3
   logic [7:0]  sh_r [4];
   logic [11:0] gt, lt, w, c;
   assign gt = {sh_r[1][3:0], sh_r[0]};
   assign lt = {sh_r[3][3:0], sh_r[2]};
   assign w = i_conversion_word;
   always_ff @(posedge i_core_clk or negedge i_rst_n) begin
      if (!i_rst_n) sh_r <= '{default: 8'h00};
      else if (i_reg_wr && i_reg_addr inside {[8'hC3:8'hC6]}) sh_r[i_reg_addr[1:0] + 2'h1] <= i_reg_wdata;
   end
   a_flag_inside: assert property (i_conversion_done && lt > gt && w > gt && w < lt |=> o_window_match_flag)
      else $error("in-window flag missing");
   a_flag_outside: assert property (i_conversion_done && lt <= gt && (w < gt || w > lt) |=> o_window_match_flag)
      else $error("out-of-window flag missing");
   a_flag_cause: assert property ($rose(o_window_match_flag) |-> $past(i_conversion_done))
      else $error("flag rose without conversion");
   a_reserved_none: assert property (o_positive_input_code[5:4] == 2'b10 |-> o_input_source == 3'h4)
      else $error("reserved code routed");
   a_temp_route: assert property (o_positive_input_code == 6'h30 |-> o_input_source == 3'h2)
      else $error("sensor not routed");
   a_supply_route: assert property (o_positive_input_code == 6'h31 |-> o_input_source == 3'h3)
      else $error("supply not routed");
   a_ground_route: assert property (o_positive_input_code >= 6'h32 |-> o_input_source == 3'h0)
      else $error("ground not routed");
   a_single_ended: assert property (o_negative_input_ground)
      else $error("negative input off ground");
   c_inside: cover property (i_conversion_done && lt > gt ##1 o_window_match_flag);
   c_outside: cover property (i_conversion_done && lt <= gt ##1 o_window_match_flag);
   c_temp: cover property (o_input_source == 3'h2);
endmodule // adc_wc_monitor
bind adc_window_compare adc_wc_monitor adc_wc_monitor_inst (.i_core_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_conversion_word, .i_conversion_done, .o_window_match_flag, .o_positive_input_code,
   .o_input_source, .o_negative_input_ground);

/* File: testbench/tb_top.sv */
// Testbench: registers, routing and window flag
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, flag, done, te;
   logic [7:0]  ad = 8'h00, wd = 8'h00, rdata;
   logic [11:0] lvl = 12'h000, word, gt, lt;
   logic [1:0]  pv = 2'h0;
   logic [2:0]  src;
   logic [31:0] oh;
   logic [3:0]  rc;
   int          n_fail = 0, n_compared = 0, cyc = 0;
   always #25 clk = ~clk;
   adc_window_compare adc_window_compare_inst (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(ad),
      .i_reg_wdata(wd), .i_reg_wr(wr), .i_reg_rd(rd), .i_conversion_word(word), .i_conversion_done(done),
      .i_package_variant(pv), .o_reg_rdata(rdata), .o_window_match_flag(flag), .o_positive_input_code(),
      .o_input_source(src), .o_pin_select_onehot(oh), .o_negative_input_ground(), .o_temp_sensor_enable(te),
      .o_reference_control(rc));
   analog_front_model analog_front_model_inst (.i_core_clk(clk), .i_source(src), .i_temp_sensor_enable(te),
      .i_pin_level(lvl), .i_go(go), .o_conversion_word(word), .o_conversion_done(done));
   function automatic logic [2:0] exp_src(logic [5:0] c, logic [1:0] p);
      if (c >= 6'h30) return (c >= 6'h32) ? 3'h0 : (c[0] ? 3'h3 : 3'h2);
      if (c >= 6'h20 || (c >= 6'h19 && p != 2'h2) || (c >= 6'h12 && p == 2'h0)) return 3'h4;
      return 3'h1;
   endfunction
   task automatic cmp(string nm, logic [11:0] e, logic [11:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_vec(string nm, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk) {ad, wd, wr} <= {a, d, 1'b1};
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] e);
      @(posedge clk) {ad, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) cmp("rdata", {4'h0, e}, {4'h0, rdata});
   endtask
   task automatic conv(logic [11:0] w);
      logic hit;
      hit = (lt > gt) ? (w > gt && w < lt) : (w < gt || w > lt);
      @(posedge clk) {lvl, go} <= {w, 1'b1};
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
      @(negedge clk) cmp("flag", {11'h0, hit}, {11'h0, flag});
      rreg(8'hE8, {7'h00, hit});
      wreg(8'hE8, 8'h00);
   endtask
   task automatic win(logic [11:0] g, logic [11:0] l);
      {gt, lt} = {g, l};
      wreg(8'hC3, g[7:0]);
      wreg(8'hC4, {4'h0, g[11:8]});
      wreg(8'hC5, l[7:0]);
      wreg(8'hC6, {4'h0, l[11:8]});
      for (int d = -1; d <= 1; d++) begin
         conv(12'(g + d));
         conv(12'(l + d));
      end
      conv(12'($urandom));
   endtask
   task automatic test_done();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      void'($urandom(32'hB65F));
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      rreg(8'hBB, 8'h3F);
      rreg(8'hC5, 8'h00);
      wreg(8'hBB, 8'hFF);
      rreg(8'hBB, 8'h3F);
      wreg(8'hD1, 8'h04);
      @(negedge clk) cmp("temp_sensor_enable", 12'h001, {11'h0, te});
      cmp("refctl", 12'h004, {8'h00, rc});
      wreg(8'hD1, 8'hF4);
      rreg(8'hD1, 8'h04);
      for (int p = 0; p < 3; p++) begin
         @(posedge clk) pv <= 2'(p);
         for (int c = 0; c < 64; c++) begin
            wreg(8'hBB, 8'(c));
            @(negedge clk) cmp("source", {9'h0, exp_src(6'(c), pv)}, {9'h0, src});
            cmp_vec("onehot", (exp_src(6'(c), pv) == 3'h1) ? (32'h0000_0001 << c) : 32'h0000_0000, oh);
         end
      end
      $display("test routing done");
      wreg(8'hBB, 8'h00);
      win(12'h100, 12'h200);
      win(12'h200, 12'h100);
      win(12'h155, 12'h155);
      repeat (20) win(12'($urandom), 12'($urandom));
      rreg(8'hC5, lt[7:0]);
      rreg(8'hC6, {4'h0, lt[11:8]});
      $display("test window done");
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) cmp("flag_rst", 12'h000, {11'h0, flag});
      cmp("temp_sensor_enable_rst", 12'h000, {11'h0, te});
      @(posedge clk) rst_n <= 1'b1;
      rreg(8'hC6, 8'h00);
      rreg(8'hBB, 8'h3F);
      $display("test reset done");
      test_done();
   end
endmodule // tb_top
